// *** rtl/fct_pkg.sv ***
// Package: constants, register map and types of the FSK caller data transmitter
package fct_pkg;
  // Register byte addresses (FIFO at control address 07 hex as index, times four)
  localparam logic [7:0] FIFO_INDEX = 8'h07;
  localparam logic [7:0] ADDR_FIFO = 8'h1c;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE = 8'h0c;
  // Control, status and enable register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_STD_BIT = 2;
  localparam int CTRL_IDLE_LSB = 3;
  localparam int CTRL_CLR_BIT = 5;
  localparam int FLAG_BIT = 0;
  localparam int FIFO_LEVEL_LSB = 8;
  localparam int BUSY_BIT = 16;
  // Idle pattern encoding
  localparam logic [1:0] IDLE_MARK = 2'h0;
  localparam logic [1:0] IDLE_SPACE = 2'h1;
  localparam logic [1:0] IDLE_SEIZE = 2'h2;
  // Timing
  localparam int CLK_HZ = 200000000;
  localparam int FRAME_HZ = 8000;
  localparam int FRAME_CYCLES = CLK_HZ / FRAME_HZ;
  localparam int BAUD = 1200;
  localparam int FRAMES_PER_3_BITS = 3 * FRAME_HZ / BAUD;
  localparam int BITS_PER_GROUP = 3;
  localparam int LONG_BIT_FRAMES = 7;
  localparam int SHORT_BIT_FRAMES = 6;
  localparam int FIFO_DEPTH = 20;
  localparam int DATA_BITS = 8;
  localparam int EOT_FIRST_BITS = 2;
  localparam int EOT_REPEAT_BITS = 8;
  // Phase increments per 8 kHz sample, 16-bit accumulator: f * 65536 / 8000
  localparam int PHASE_W = 16;
  localparam logic [15:0] INC_B_MARK = 16'(1200 * 65536 / 8000);
  localparam logic [15:0] INC_B_SPACE = 16'(2200 * 65536 / 8000);
  localparam logic [15:0] INC_V_MARK = 16'(1300 * 65536 / 8000);
  localparam logic [15:0] INC_V_SPACE = 16'(2100 * 65536 / 8000);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic irq_select;
    logic standard;
    logic [1:0] idle;
  } fct_ctrl_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fct_sample_s;

  typedef enum logic [1:0] {
    FCT_IDLE,
    FCT_START,
    FCT_DATA,
    FCT_STOP
  } fct_tx_e;
endpackage

// *** rtl/fct_modulator.sv ***
// Phase-continuous FSK tone generator producing 8-bit PCM samples
`timescale 1ns/1ps
module fct_modulator (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_tick,
  input wire logic bit_value,
  input wire logic standard,
  input wire logic active,
  output fct_pkg::fct_sample_s sample
);
  logic [fct_pkg::PHASE_W-1:0] phase;
  logic [fct_pkg::PHASE_W-1:0] inc;
  logic [6:0] tri_mag;
  logic [7:0] lin;

  always_comb begin
    if (standard)
      inc = bit_value ? fct_pkg::INC_V_MARK : fct_pkg::INC_V_SPACE;
    else
      inc = bit_value ? fct_pkg::INC_B_MARK : fct_pkg::INC_B_SPACE;
  end

  // Only the increment changes at a bit edge, never the phase, so no waveform jump
  always_ff @(posedge aclk) begin
    if (!aresetn)
      phase <= '0;
    else if (frame_tick && active)
      phase <= phase + inc;
  end

  // Triangle approximation of the sine keeps the table out; folded to sign-magnitude
  always_comb begin
    tri_mag = phase[14] ? ~phase[13:7] : phase[13:7];
    lin = {phase[15], tri_mag};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      sample <= '0;
    else begin
      sample.valid <= frame_tick && active;
      if (frame_tick && active)
        sample.data <= lin;
    end
  end
endmodule

// *** rtl/fct_transmitter.sv ***
// FSK caller data transmitter with AXI4-Lite registers and 20-byte FIFO
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fct_transmitter #(
  parameter int DEPTH = fct_pkg::FIFO_DEPTH,
  parameter int FRAME_CYCLES = fct_pkg::FRAME_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic store_we,
  output logic [7:0] switch_sample_store
);
  if (DEPTH < 2 || DEPTH > 255 || FRAME_CYCLES < 2) begin : g_bad_params
    $error("fct_transmitter: unsupported parameter values");
  end

  localparam int PW = $clog2(DEPTH);
  localparam int FW = $clog2(FRAME_CYCLES);

  fct_pkg::fct_ctrl_s ringer_fsk_control_reg;
  logic fsk_irq_flag;
  logic fsk_irq_enable;
  logic [7:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [7:0] level;
  logic [FW-1:0] frame_cnt;
  logic frame_tick;
  logic [1:0] phase3;
  logic [2:0] frames_in_bit;
  logic bit_tick;
  fct_pkg::fct_tx_e tx_state;
  logic [7:0] shift;
  logic [2:0] bit_idx;
  logic tx_bit;
  logic seize_toggle;
  logic [3:0] idle_cnt;
  logic eot_first_done;
  logic fifo_pop;
  logic fifo_push;
  logic fifo_clear;
  logic empty_event;
  logic eot_event;
  logic have_aw;
  logic have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  fct_pkg::fct_sample_s sample;

  // Write channel: address and data latched independently, answered after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      have_aw <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write)
      have_aw <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_w <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      have_w <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write)
      have_w <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !have_aw && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !have_w && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign do_write = have_aw && have_w && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fct_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        fct_pkg::ADDR_FIFO, fct_pkg::ADDR_CTRL, fct_pkg::ADDR_STATUS,
        fct_pkg::ADDR_ENABLE: s_axi_bresp <= fct_pkg::RESP_OKAY;
        default: s_axi_bresp <= fct_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  assign fifo_push = do_write && aw_addr == fct_pkg::ADDR_FIFO && w_strb[0]
    && level < 8'(DEPTH);
  assign fifo_clear = do_write && aw_addr == fct_pkg::ADDR_CTRL && w_strb[0]
    && w_data[fct_pkg::CTRL_CLR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn)
      ringer_fsk_control_reg <= '0;
    else if (do_write && aw_addr == fct_pkg::ADDR_CTRL && w_strb[0]) begin
      ringer_fsk_control_reg.enable <= w_data[fct_pkg::CTRL_EN_BIT];
      ringer_fsk_control_reg.irq_select <= w_data[fct_pkg::CTRL_SEL_BIT];
      ringer_fsk_control_reg.standard <= w_data[fct_pkg::CTRL_STD_BIT];
      ringer_fsk_control_reg.idle <= w_data[fct_pkg::CTRL_IDLE_LSB +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      fsk_irq_enable <= 1'b0;
    else if (do_write && aw_addr == fct_pkg::ADDR_ENABLE && w_strb[0])
      fsk_irq_enable <= w_data[fct_pkg::FLAG_BIT];
  end

  // Write-one-to-clear; a new event in the same cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      fsk_irq_flag <= 1'b0;
    else if (empty_event || eot_event)
      fsk_irq_flag <= 1'b1;
    else if (do_write && aw_addr == fct_pkg::ADDR_STATUS && w_strb[0]
             && w_data[fct_pkg::FLAG_BIT])
      fsk_irq_flag <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= fsk_irq_flag && fsk_irq_enable;
  end

  // Read channel, one cycle after address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= fct_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= fct_pkg::RESP_OKAY;
        s_axi_rdata <= '0;
        case (s_axi_araddr)
          fct_pkg::ADDR_CTRL: begin
            s_axi_rdata[fct_pkg::CTRL_EN_BIT] <= ringer_fsk_control_reg.enable;
            s_axi_rdata[fct_pkg::CTRL_SEL_BIT] <= ringer_fsk_control_reg.irq_select;
            s_axi_rdata[fct_pkg::CTRL_STD_BIT] <= ringer_fsk_control_reg.standard;
            s_axi_rdata[fct_pkg::CTRL_IDLE_LSB +: 2] <= ringer_fsk_control_reg.idle;
            s_axi_rdata[fct_pkg::FIFO_LEVEL_LSB +: 8] <= level;
            s_axi_rdata[fct_pkg::BUSY_BIT] <= tx_state != fct_pkg::FCT_IDLE;
          end
          fct_pkg::ADDR_STATUS: s_axi_rdata[fct_pkg::FLAG_BIT] <= fsk_irq_flag;
          fct_pkg::ADDR_ENABLE: s_axi_rdata[fct_pkg::FLAG_BIT] <= fsk_irq_enable;
          fct_pkg::ADDR_SAMPLE: s_axi_rdata[7:0] <= switch_sample_store;
          fct_pkg::ADDR_FIFO: ;
          default: s_axi_rresp <= fct_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // FIFO storage and pointers
  always_ff @(posedge aclk) begin
    if (fifo_push)
      mem[wr_ptr] <= w_data[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || fifo_clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (fifo_push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (fifo_pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      level <= level + 8'(fifo_push) - 8'(fifo_pop);
    end
  end

  // 8 kHz frame pulse from the system clock
  always_ff @(posedge aclk) begin
    if (!aresetn)
      frame_cnt <= '0;
    else
      frame_cnt <= (frame_cnt == FW'(FRAME_CYCLES - 1)) ? '0 : frame_cnt + 1'b1;
  end

  assign frame_tick = frame_cnt == FW'(FRAME_CYCLES - 1);

  // Bits of 7, 7, 6 frames: three bits in twenty frames, 6 2/3 on average
  always_ff @(posedge aclk) begin
    if (!aresetn || !ringer_fsk_control_reg.enable) begin
      frames_in_bit <= '0;
      phase3 <= '0;
    end else if (frame_tick) begin
      if (bit_tick) begin
        frames_in_bit <= '0;
        phase3 <= (phase3 == 2'(fct_pkg::BITS_PER_GROUP - 1)) ? 2'h0 : phase3 + 1'b1;
      end else
        frames_in_bit <= frames_in_bit + 1'b1;
    end
  end

  assign bit_tick = frame_tick && frames_in_bit ==
    ((phase3 == 2'(fct_pkg::BITS_PER_GROUP - 1)) ? 3'(fct_pkg::SHORT_BIT_FRAMES - 1)
                                               : 3'(fct_pkg::LONG_BIT_FRAMES - 1));

  // Start bit at each boundary only if a byte is waiting: boundary lands at most 1 bit later
  assign fifo_pop = bit_tick && level != 8'h00 && !fifo_clear &&
    (tx_state == fct_pkg::FCT_IDLE || tx_state == fct_pkg::FCT_STOP);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ringer_fsk_control_reg.enable) begin
      tx_state <= fct_pkg::FCT_IDLE;
      shift <= '0;
      bit_idx <= '0;
    end else if (bit_tick) begin
      unique case (tx_state)
        fct_pkg::FCT_IDLE, fct_pkg::FCT_STOP: begin
          if (fifo_pop) begin
            tx_state <= fct_pkg::FCT_START;
            shift <= mem[rd_ptr];
          end else
            tx_state <= fct_pkg::FCT_IDLE;
        end
        fct_pkg::FCT_START: begin
          tx_state <= fct_pkg::FCT_DATA;
          bit_idx <= '0;
        end
        fct_pkg::FCT_DATA: begin
          shift <= {1'b0, shift[7:1]};
          bit_idx <= bit_idx + 1'b1;
          if (bit_idx == 3'(fct_pkg::DATA_BITS - 1))
            tx_state <= fct_pkg::FCT_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ringer_fsk_control_reg.enable)
      seize_toggle <= 1'b0;
    else if (bit_tick && tx_state == fct_pkg::FCT_IDLE)
      seize_toggle <= !seize_toggle;
  end

  always_comb begin
    unique case (tx_state)
      fct_pkg::FCT_START: tx_bit = 1'b0;
      fct_pkg::FCT_DATA: tx_bit = shift[0];
      fct_pkg::FCT_STOP: tx_bit = 1'b1;
      fct_pkg::FCT_IDLE: begin
        if (ringer_fsk_control_reg.idle == fct_pkg::IDLE_SEIZE)
          tx_bit = seize_toggle;
        else
          tx_bit = ringer_fsk_control_reg.idle != fct_pkg::IDLE_SPACE;
      end
    endcase
  end

  // Empty interrupt on the pop that drains the FIFO, never on a clear
  // A byte pushed in the same cycle means the FIFO never actually empties
  assign empty_event = !ringer_fsk_control_reg.irq_select && fifo_pop && !fifo_push
    && level == 8'h01;

  // Idle bit counter; idle pattern is not an input, so a change never restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn || !ringer_fsk_control_reg.enable) begin
      idle_cnt <= '0;
      eot_first_done <= 1'b0;
    end else if (bit_tick) begin
      if (tx_state != fct_pkg::FCT_IDLE || fifo_pop) begin
        idle_cnt <= '0;
        eot_first_done <= 1'b0;
      end else if (eot_event) begin
        idle_cnt <= '0;
        eot_first_done <= 1'b1;
      end else
        idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // Counted at the end of each idle bit
  assign eot_event = bit_tick && ringer_fsk_control_reg.irq_select
    && tx_state == fct_pkg::FCT_IDLE && !fifo_pop
    && idle_cnt == (eot_first_done ? 4'(fct_pkg::EOT_REPEAT_BITS - 1)
                                   : 4'(fct_pkg::EOT_FIRST_BITS - 1));

  fct_modulator u_mod (
    .aclk(aclk),
    .aresetn(aresetn),
    .frame_tick(frame_tick),
    .bit_value(tx_bit),
    .standard(ringer_fsk_control_reg.standard),
    .active(ringer_fsk_control_reg.enable),
    .sample(sample)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_we <= 1'b0;
      switch_sample_store <= '0;
    end else begin
      store_we <= sample.valid;
      if (sample.valid)
        switch_sample_store <= sample.data;
    end
  end
endmodule

// *** testbench/fct_properties.sv ***
// Port-level checker for the FSK caller data transmitter
`timescale 1ns/1ps
module fct_checker #(
  parameter int FRAME_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic store_we,
  input wire logic [7:0] switch_sample_store
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int gap;
  // Cycles since the last sample strobe; a pause in transmission only lengthens it
  always_ff @(posedge aclk) begin
    if (!aresetn || store_we) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  AST_WE_PULSE: assert property (store_we |=> !store_we)
    else $error("sample strobe longer than one cycle");
  AST_WE_GAP: assert property (store_we |-> gap >= FRAME_CYCLES - 1)
    else $error("sample strobes closer than one frame");
  AST_SAMPLE_HOLD: assert property (!store_we |-> $stable(switch_sample_store))
    else $error("sample changed without strobe");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_SOON: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("second write accepted");
  COV_IRQ: cover property ($rose(irq));
  COV_WE: cover property (store_we);
  COV_ERR: cover property (s_axi_rvalid && s_axi_rresp == fct_pkg::RESP_SLVERR);
endmodule

// *** testbench/fct_store_model.sv ***
// Behavioural switch sample store: counts frames and tone sign changes
`timescale 1ns/1ps
module fct_store_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic store_we,
  input wire logic [7:0] switch_sample_store,
  output int frames,
  output int flips
);
  logic last_sign;
  // Sign changes stand in for zero crossings, so tone frequency shows as a count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames <= 0;
      flips <= 0;
      last_sign <= 1'b0;
    end else if (store_we) begin
      frames <= frames + 1;
      last_sign <= switch_sample_store[7];
      if (switch_sample_store[7] != last_sign) begin
        flips <= flips + 1;
      end
    end
  end
endmodule

// *** testbench/tb.sv ***
// Testbench for the FSK caller data transmitter
`timescale 1ns/1ps
module tb;
  localparam int FC = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic irq;
  logic store_we;
  logic [7:0] switch_sample_store;
  logic [31:0] d;
  logic [1:0] r;
  int frames, flips, f0, f1, f2;
  int fails = 0;
  int n_tests = 0;
  always #2.5 aclk = ~aclk;
  fct_transmitter #(.FRAME_CYCLES(FC)) i_fct_transmitter (.*);
  fct_store_model i_fct_store_model (.*);
  task automatic conclude;
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input int v, input int lo, input int hi);
    n_tests++;
    if (v < lo || v > hi) begin
      fails++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 200);
    chk(32'(t < 200), 32'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 200);
    chk(32'(t < 200), 32'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] cv(input int en, input int sel, input int std, input int idle);
    return 32'(en) << fct_pkg::CTRL_EN_BIT | 32'(sel) << fct_pkg::CTRL_SEL_BIT
      | 32'(std) << fct_pkg::CTRL_STD_BIT | 32'(idle) << fct_pkg::CTRL_IDLE_LSB;
  endfunction
  task automatic wait_frames(input int n);
    int s;
    int t;
    s = frames;
    t = 0;
    while (frames - s < n && t < n * FC * 2 + 20) begin
      @(posedge aclk);
      t++;
    end
    chk(32'(frames - s >= n), 32'h1);
  endtask
  task automatic wait_irq(output int f);
    int t;
    t = 0;
    while (irq !== 1'b1 && t < 2000) begin
      @(posedge aclk);
      t++;
    end
    f = frames;
    chk(32'(irq), 32'h1);
  endtask
  task automatic s_regs;
    rd(fct_pkg::ADDR_CTRL);
    chk(d, 32'h0);
    rd(fct_pkg::ADDR_STATUS);
    chk(d, 32'h0);
    rd(fct_pkg::ADDR_FIFO);
    chk(d, 32'h0);
    rd(8'h40);
    chk(32'(r), 32'(fct_pkg::RESP_SLVERR));
    wr(8'h44, 32'h1);
    chk(32'(r), 32'(fct_pkg::RESP_SLVERR));
  endtask
  task automatic s_mask;
    wr(fct_pkg::ADDR_ENABLE, 32'h0);
    wr(fct_pkg::ADDR_CTRL, cv(1, 1, 0, 0));
    wait_frames(20);
    chk(32'(irq), 32'h0);
    rd(fct_pkg::ADDR_STATUS);
    chk(32'(d[fct_pkg::FLAG_BIT]), 32'h1);
    wr(fct_pkg::ADDR_ENABLE, 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(fct_pkg::ADDR_CTRL, 32'h0);
    wr(fct_pkg::ADDR_STATUS, 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0);
  endtask
  task automatic s_eot;
    wr(fct_pkg::ADDR_CTRL, cv(0, 1, 0, 2));
    wr(fct_pkg::ADDR_CTRL, cv(1, 1, 0, 2));
    f0 = frames;
    wait_irq(f1);
    chkr(f1 - f0, 13, 15);
    wr(fct_pkg::ADDR_STATUS, 32'h1);
    // Change idle well inside the 8-bit span so a restarted count would show
    wait_frames(20);
    wr(fct_pkg::ADDR_CTRL, cv(1, 1, 0, 0));
    wait_irq(f2);
    chkr(f2 - f1, 52, 55);
    wr(fct_pkg::ADDR_CTRL, 32'h0);
    wr(fct_pkg::ADDR_STATUS, 32'h1);
  endtask
  task automatic s_fifo;
    for (int i = 0; i < 21; i++) wr(fct_pkg::ADDR_FIFO, 32'(i));
    rd(fct_pkg::ADDR_CTRL);
    chk(32'(d[fct_pkg::FIFO_LEVEL_LSB +: 8]), 32'h14);
    wr(fct_pkg::ADDR_CTRL, 32'h1 << fct_pkg::CTRL_CLR_BIT);
    rd(fct_pkg::ADDR_CTRL);
    chk(32'(d[fct_pkg::FIFO_LEVEL_LSB +: 8]), 32'h0);
    wr(fct_pkg::ADDR_CTRL, cv(1, 0, 0, 0));
    wait_frames(20);
    rd(fct_pkg::ADDR_STATUS);
    chk(d, 32'h0);
  endtask
  task automatic s_byte;
    wr(fct_pkg::ADDR_FIFO, 32'ha5);
    f0 = frames;
    wait_irq(f1);
    chkr(f1 - f0, 0, 14);
    rd(fct_pkg::ADDR_CTRL);
    chk(32'(d[fct_pkg::BUSY_BIT]), 32'h1);
    wr(fct_pkg::ADDR_STATUS, 32'h1);
    wr(fct_pkg::ADDR_CTRL, cv(1, 1, 0, 0));
    wait_irq(f2);
    chkr(f2 - f1, 72, 81);
    rd(fct_pkg::ADDR_CTRL);
    chk(32'(d[fct_pkg::BUSY_BIT]), 32'h0);
    wr(fct_pkg::ADDR_STATUS, 32'h1);
  endtask
  task automatic s_tone;
    // Idle pattern, standard and expected sign changes in 40 frames
    int ti[5] = '{0, 1, 0, 1, 2};
    int ts[5] = '{0, 0, 1, 1, 0};
    int te[5] = '{12, 22, 13, 21, 17};
    for (int i = 0; i < 5; i++) begin
      wr(fct_pkg::ADDR_CTRL, cv(1, 1, ts[i], ti[i]));
      wait_frames(3);
      f0 = flips;
      wait_frames(40);
      chkr(flips - f0, te[i] - 3, te[i] + 3);
    end
    wr(fct_pkg::ADDR_CTRL, 32'h0);
    // A strobe launched just before the disable still reaches the store
    repeat (4) @(posedge aclk);
    f0 = frames;
    repeat (10 * FC) @(posedge aclk);
    chk(32'(frames - f0), 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    s_mask();
    s_eot();
    s_fifo();
    s_byte();
    s_tone();
    conclude();
  end
  // The whole sequence needs about 2000 cycles; this leaves ample margin
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule
bind fct_transmitter fct_checker #(.FRAME_CYCLES(FRAME_CYCLES)) i_fct_checker (.*);
